/* File: chk_if.sv */
// carrier between the monitor and one continuity checker
// assumes both ends sit on the same clock
`timescale 1ns/10ps
`default_nettype none
interface chk_if #(parameter int W = 16);
    logic         en;
    logic         clr;
    logic [W-1:0] val;
    logic [W-1:0] step;
    logic         err;
    modport owner (output en, output clr, output val, output step, input err);
    modport chk   (input en, input clr, input val, input step, output err);
endinterface
`default_nettype wire

/* File: cont_check.sv */
// continuity checker: each sample must equal the previous one plus step
// assumes en and clr are single-cycle strobes from the owner
`timescale 1ns/10ps
`default_nettype none
module cont_check (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // checked value
    chk_if.chk       c
);
    localparam int W = $bits(c.val);
    logic [W-1:0] prev_r;
    logic         have_r;
    logic         err_r;
    wire logic [W-1:0] expect_w = prev_r + c.step;
    // sum wraps at 2**W, so a counter rolling over is not an error
    wire logic mismatch = c.en & have_r & (c.val != expect_w);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
            have_r <= 1'b0;
            err_r  <= 1'b0;
        end else begin
            err_r <= mismatch;
            // a sample that lands with the clear becomes the new reference
            if (c.en) begin
                prev_r <= c.val;
                have_r <= 1'b1;
            end else if (c.clr) begin
                have_r <= 1'b0;
            end
        end
    end
    assign c.err = err_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    step_err_a: assert property ((c.en && have_r) |=>
        (c.err == ($past(c.val) != W'($past(prev_r) + $past(c.step)))))
        else $error("continuity error not tied to step mismatch");
    first_quiet_a: assert property ((c.en && !have_r) |=> !c.err)
        else $error("error raised without a previous sample");
endmodule
`default_nettype wire

/* File: hdr_classify.sv */
// classifies the latched payload header and source format words
// assumes the words only change when a datagram is committed
`timescale 1ns/10ps
`default_nettype none
module hdr_classify import mhm_pkg::*; (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // latched header words
    input wire logic        video,
    input wire logic [31:0] hbr,
    input wire logic [31:0] fmt,
    // decode flags
    output logic     [15:0] dec
);
    wire logic [2:0] vsid   = hbr[HB_VSID+:3];
    wire logic [1:0] tref   = hbr[HB_REF+:2];
    wire logic [1:0] scr    = hbr[HB_SCR+:2];
    wire logic [2:0] fec    = hbr[HB_FEC+:3];
    wire logic [3:0] cf     = hbr[HB_CF+:4];
    wire logic [3:0] map    = fmt[FM_MAP+:4];
    wire logic [7:0] frame  = fmt[FM_FRM+:8];
    wire logic [7:0] frate  = fmt[FM_RATE+:8];
    wire logic [3:0] sample = fmt[FM_SMP+:4];
    wire logic [1:0] vsid_cls = (vsid == 3'h0) ? 2'h0 : (vsid == 3'h1) ? 2'h1 : 2'h2;
    wire logic ref_bad  = (tref == 2'h1);
    wire logic scr_rsv  = (scr != 2'h0);
    wire logic [1:0] fec_cls = (fec > 3'h2) ? 2'h3 : fec[1:0];
    wire logic cf_rsv   = (cf > 4'h5);
    wire logic fmt_on   = video & hbr[HB_F];
    wire logic [1:0] map_cls = (map > 4'h2) ? 2'h3 : map[1:0];
    wire logic frame_ok = frame inside {8'h00, 8'h10, 8'h11, [8'h20:8'h24], 8'h30};
    wire logic frate_ok = (frate <= 8'h04) | ((frate >= 8'h10) & (frate <= 8'h1B)
                          & (frate != 8'h13) & (frate != 8'h19));
    wire logic sample_ok = (sample <= 4'h8) & (sample != 4'h4);
    wire logic rsv_bad  = (hbr[HB_RSV+:5] != 5'h00);
    wire logic [15:0] dec_nxt = !video ? 16'h0000 :
        {rsv_bad, fmt_on & sample_ok, fmt_on & frate_ok, fmt_on & frame_ok,
         fmt_on ? map_cls : 2'h0, fmt_on, cf_rsv, fec_cls, scr_rsv, ref_bad, tref, vsid_cls};
    logic [15:0] dec_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_r <= 16'h0000;
        end else begin
            dec_r <= dec_nxt;
        end
    end
    assign dec = dec_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    vsid_class_a: assert property ((video && hbr[HB_VSID+:3] > 3'h1) |=> dec[1:0] == 2'h2)
        else $error("reserved source id not flagged");
    fec_class_a: assert property ((video && hbr[HB_FEC+:3] == 3'h1) |=> dec[7:6] == 2'h1)
        else $error("column fec not decoded");
    cf_rsv_a: assert property (video |=> dec[8] == ($past(hbr[HB_CF+:4]) >= 4'h6))
        else $error("clock code reserved flag wrong");
    fmt_gate_a: assert property (!hbr[HB_F] |=> dec[14:9] == 6'h00)
        else $error("format fields shown while absent");
endmodule
`default_nettype wire

/* File: media_header_monitor.sv */
// receive-side header monitor for media datagrams, registers on APB
// assumes rx_* comes from the same clock domain, one word per rx_valid
`timescale 1ns/10ps
`default_nettype none
module media_header_monitor import mhm_pkg::*; (
    // apb slave
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    output logic     [31:0] prdata,
    output logic            pready,
    output logic            pslverr,
    // receive datagram stream
    input wire logic        rx_valid,
    input wire logic        rx_sop,
    input wire logic        rx_eop,
    input wire logic [31:0] rx_data,
    // payload out and status
    output logic            pay_valid,
    output logic [31:0]     pay_data,
    output logic            err_any
);
    // apb decode
    logic [31:0] ctrl_r, astep_r, vstep_r, prdata_r;
    logic        pready_r, pslverr_r, clr_r;
    wire logic setup = psel & ~penable;
    wire logic wen   = psel & penable & pready_r & pwrite;
    wire logic hit   = paddr inside {A_CTRL, A_ASTEP, A_VSTEP, A_ERR, A_RTP, A_HBR,
                                     A_FMT, A_VTS, A_DEC};
    wire logic video = ctrl_r[C_VIDEO];

    // parser state
    prs_state_t  state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [31:0] rtp_w_r, ts_w_r, hbr_w_r, fmt_w_r, vts_w_r;
    logic [31:0] rtp_s_r, hbr_s_r, fmt_s_r, vts_s_r;
    logic        pay_valid_r, first_r;
    logic [31:0] pay_data_r;
    logic [ERR_W-1:0] err_r;
    logic [15:0] dec;

    wire logic acc    = rx_valid;
    wire logic [3:0] cc  = rtp_w_r[RT_CC+:4];
    wire logic [3:0] ext = hbr_w_r[HB_EXT+:4];
    wire logic [3:0] cf  = hbr_w_r[HB_CF+:4];
    wire logic commit = acc & rx_eop & ~rx_sop & (state_r == ST_PAY);
    wire logic ver_bad  = commit & ~video & (rtp_w_r[RT_VER+:2] != RTP_VER);
    wire logic csrc_bad = commit & ~video & (cc != 4'h0);
    wire logic pay_word = acc & ~rx_sop & (state_r == ST_PAY);

    // next state of the header walk
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_TS:   state_nxt = ST_SSRC;
            ST_SSRC: begin
                cnt_nxt = cc;
                if (cc != 4'h0) begin
                    state_nxt = ST_CSRC;
                end else begin
                    state_nxt = video ? ST_HBR : ST_PAY;
                end
            end
            ST_CSRC: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    state_nxt = video ? ST_HBR : ST_PAY;
                end
            end
            ST_HBR: state_nxt = ST_FMT;
            ST_FMT: begin
                cnt_nxt = ext;
                if (cf != 4'h0) begin
                    state_nxt = ST_VTS;
                end else begin
                    state_nxt = (ext != 4'h0) ? ST_EXT : ST_PAY;
                end
            end
            ST_VTS: begin
                cnt_nxt = ext;
                state_nxt = (ext != 4'h0) ? ST_EXT : ST_PAY;
            end
            ST_EXT: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    state_nxt = ST_PAY;
                end
            end
            ST_PAY: state_nxt = ST_PAY;
            default: state_nxt = ST_IDLE;
        endcase
        if (acc & rx_sop) begin
            state_nxt = ST_TS;
        end else if (acc & rx_eop) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
        end else if (acc) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // capture the words of the datagram being walked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtp_w_r <= 32'h0;
            ts_w_r  <= 32'h0;
            hbr_w_r <= 32'h0;
            fmt_w_r <= 32'h0;
            vts_w_r <= 32'h0;
        end else if (acc) begin
            if (rx_sop) rtp_w_r <= rx_data;
            if (!rx_sop && state_r == ST_TS) ts_w_r <= rx_data;
            if (!rx_sop && state_r == ST_HBR) hbr_w_r <= rx_data;
            if (!rx_sop && state_r == ST_FMT) fmt_w_r <= rx_data;
            if (!rx_sop && state_r == ST_VTS) vts_w_r <= rx_data;
            if (rx_sop) vts_w_r <= 32'h0;
        end
    end

    // shadows hold the last complete datagram; video words stay zero for audio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtp_s_r <= 32'h0;
            hbr_s_r <= 32'h0;
            fmt_s_r <= 32'h0;
            vts_s_r <= 32'h0;
            first_r <= 1'b1;
        end else if (commit) begin
            rtp_s_r <= rtp_w_r;
            hbr_s_r <= video ? hbr_w_r : 32'h0;
            fmt_s_r <= (video & hbr_w_r[HB_F]) ? fmt_w_r : 32'h0;
            vts_s_r <= video ? vts_w_r : 32'h0;
            first_r <= rtp_w_r[RT_M];
        end
    end

    // continuity checks: sequence, timestamp, frame count
    chk_if #(.W(16)) seq_c ();
    chk_if #(.W(32)) ts_c ();
    chk_if #(.W(8))  fc_c ();
    assign seq_c.en   = commit;
    assign seq_c.clr  = clr_r;
    assign seq_c.val  = rtp_w_r[15:0];
    assign seq_c.step = 16'h0001;
    assign ts_c.en    = commit;
    assign ts_c.clr   = clr_r;
    assign ts_c.val   = ts_w_r;
    assign ts_c.step  = video ? vstep_r : astep_r;
    // only the first datagram of a frame advances the count
    assign fc_c.en    = commit & video & first_r;
    assign fc_c.clr   = clr_r;
    assign fc_c.val   = hbr_w_r[HB_FRC+:8];
    assign fc_c.step  = 8'h01;
    cont_check u_seq (.clk(pclk), .rst_n(presetn), .c(seq_c));
    cont_check u_ts  (.clk(pclk), .rst_n(presetn), .c(ts_c));
    cont_check u_fc  (.clk(pclk), .rst_n(presetn), .c(fc_c));

    hdr_classify u_cls (
        .clk   (pclk),
        .rst_n (presetn),
        .video (video),
        .hbr   (hbr_s_r),
        .fmt   (fmt_s_r),
        .dec   (dec)
    );

    // sticky errors; a new event in the clearing cycle survives
    wire logic [ERR_W-1:0] err_set = {csrc_bad, ver_bad, ts_c.err, seq_c.err, fc_c.err};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_r <= '0;
        end else begin
            err_r <= (err_r & {ERR_W{~clr_r}}) | err_set;
        end
    end

    // payload stream after header and extension words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pay_valid_r <= 1'b0;
            pay_data_r  <= 32'h0;
        end else begin
            pay_valid_r <= pay_word;
            if (pay_word) pay_data_r <= rx_data;
        end
    end

    // apb registers
    wire logic [31:0] rd_mux =
        (paddr == A_CTRL)  ? ctrl_r :
        (paddr == A_ASTEP) ? astep_r :
        (paddr == A_VSTEP) ? vstep_r :
        (paddr == A_ERR)   ? {27'h0, err_r} :
        (paddr == A_RTP)   ? rtp_s_r :
        (paddr == A_HBR)   ? hbr_s_r :
        (paddr == A_FMT)   ? fmt_s_r :
        (paddr == A_VTS)   ? vts_s_r :
        (paddr == A_DEC)   ? {16'h0, dec} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~hit;
            if (setup) prdata_r <= hit ? rd_mux : 32'h0;
        end
    end

    // the clear bit never stores; it only fires the one-cycle session reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= CTRL_RST;
            astep_r <= ASTEP_RST;
            vstep_r <= VSTEP_RST;
            clr_r   <= 1'b0;
        end else begin
            clr_r <= wen & (paddr == A_CTRL) & pwdata[C_CLR];
            if (wen && paddr == A_CTRL) ctrl_r <= {31'h0, pwdata[C_VIDEO]};
            if (wen && paddr == A_ASTEP) astep_r <= pwdata;
            if (wen && paddr == A_VSTEP) vstep_r <= pwdata;
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign pay_valid = pay_valid_r;
    assign pay_data  = pay_data_r;
    logic err_any_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_any_r <= 1'b0;
        end else begin
            err_any_r <= |((err_r & {ERR_W{~clr_r}}) | err_set);
        end
    end
    assign err_any = err_any_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ver_err_a: assert property (ver_bad |=> err_r[E_VER])
        else $error("bad rtp version not flagged");
    csrc_err_a: assert property (csrc_bad |=> err_r[E_CSRC] ##1 err_any)
        else $error("nonzero csrc count not flagged");
    err_hold_a: assert property ((err_r[E_SEQ] && !clr_r) |=> err_r[E_SEQ])
        else $error("sticky sequence error dropped");
    set_wins_a: assert property ((clr_r && seq_c.err) |=> err_r[E_SEQ])
        else $error("event lost against clear");
    video_only_a: assert property ((commit && !video) |=> hbr_s_r == 32'h0)
        else $error("payload header latched for audio");
    ext_skip_a: assert property ((acc && !rx_sop && state_r == ST_EXT) |=> !pay_valid)
        else $error("extension word passed as payload");
    pay_follow_a: assert property (pay_word |=> pay_valid && pay_data == $past(rx_data))
        else $error("payload word not forwarded");
    hdr_latch_a: assert property (commit |=> rtp_s_r == $past(rtp_w_r))
        else $error("header of good datagram not latched");
    apb_ready_a: assert property (setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    seq_cov: cover property (commit && seq_c.err == 1'b0 ##1 seq_c.err);
    fc_cov: cover property (fc_c.en ##1 fc_c.err);
    ext_cov: cover property (state_r == ST_EXT ##[1:20] commit);
    clr_cov: cover property (err_any ##[1:50] clr_r);
endmodule
`default_nettype wire

/* File: media_header_monitor_tb_top.sv */
// self-checking bench: apb master, decode table, continuity errors
// assumes the sender model drives the receive stream on pclk
`timescale 1ns/10ps
`default_nettype none
module media_header_monitor_tb_top import mhm_pkg::*; ;
    typedef struct packed {
        logic        vid;
        logic [31:0] hdr;
        logic [31:0] fmt;
        logic [15:0] dec;
    } row_t;
    logic        pclk, presetn, psel, penable, pwrite, se;
    logic        pready, pslverr, rx_valid, rx_sop, rx_eop, pay_valid, err_any;
    logic [7:0]  paddr;
    logic [15:0] seq;
    logic [31:0] pwdata, prdata, rx_data, pay_data, rd, ts;
    int          err_count, compares, pay_cnt, cyc;
    row_t        rows [0:5];

    media_header_monitor u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_data(rx_data), .pay_valid(pay_valid),
        .pay_data(pay_data), .err_any(err_any));
    media_sender u_snd (.pclk(pclk), .rx_valid(rx_valid), .rx_sop(rx_sop),
        .rx_eop(rx_eop), .rx_data(rx_data));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (pay_valid === 1'b1) pay_cnt <= pay_cnt + 1;
        if (cyc == 6000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb wait", 32'h1, n);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    task automatic pkt(input logic vid, input logic mk, input logic [1:0] v,
                       input logic [3:0] cc, input logic [15:0] ds, input logic [31:0] dt,
                       input logic [31:0] hdr, input logic [31:0] fmt, input logic [7:0] sk);
        int p0;
        p0 = pay_cnt;
        seq = seq + ds;
        ts = ts + dt;
        u_snd.send(vid, {v, 2'h0, cc, mk, 7'h62, seq}, ts, hdr, fmt, sk);
        // decode flags settle two cycles after commit
        repeat (4) @(posedge pclk);
        chk("payload words", 32'h2, p0 - pay_cnt + 4);
        chk("payload data", 32'hA000_0001, pay_data);
    endtask

    task automatic aud(input logic [15:0] ds, input logic [31:0] dt,
                       input logic [1:0] v, input logic [3:0] cc);
        pkt(1'b0, 1'b0, v, cc, ds, dt, 32'h0, 32'h0, 8'h0);
    endtask

    task automatic vpk(input logic mk, input logic [31:0] dt, input logic [7:0] sk);
        pkt(1'b1, mk, 2'h2, 4'h0, 16'h1, dt, rows[0].hdr, rows[0].fmt, sk);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_count = 0;
        compares = 0;
        pay_cnt = 0;
        cyc = 0;
        seq = 16'hFFF0;
        ts = 32'h0;
        rows[0] = {1'b1, 32'h0800_8020, 32'h0201_0100, 16'h7208};
        rows[1] = {1'b1, 32'h1900_52C0, 32'h1131_3400, 16'h0775};
        rows[2] = {1'b1, 32'h0500_F400, 32'h2001_0100, 16'h00AE};
        rows[3] = {1'b1, 32'h0800_07E0, 32'h2301_B800, 16'h7BC0};
        rows[4] = {1'b1, 32'h0800_0EA0, 32'h3250_4000, 16'h6EC0};
        rows[5] = {1'b0, 32'h0800_8020, 32'h0201_0100, 16'h0000};
        repeat (20) @(posedge pclk);
        chk("outputs in reset", 32'h0, {28'h0, pready, pslverr, pay_valid, err_any});
        presetn <= 1'b1;
        rchk("ctrl reset", A_CTRL, CTRL_RST);
        rchk("astep reset", A_ASTEP, ASTEP_RST);
        rchk("vstep reset", A_VSTEP, VSTEP_RST);
        apb(1'b1, A_ERR, 32'h1F);
        rchk("err read only", A_ERR, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped slverr", 32'h1, {31'h0, se});
        chk("unmapped data", 32'h0, rd);
        $display("test reset and registers done");
        foreach (rows[i]) begin
            apb(1'b1, A_CTRL, {31'h0, rows[i].vid});
            pkt(rows[i].vid, 1'b1, 2'h2, 4'h0, 16'h1, 32'h30, rows[i].hdr, rows[i].fmt, 8'h0);
            rchk("decode flags", A_DEC, {16'h0, rows[i].dec});
        end
        rchk("last rtp word", A_RTP, {9'h101, 7'h62, seq});
        rchk("audio hbr word", A_HBR, 32'h0);
        $display("test decode table done");
        apb(1'b1, A_CTRL, 32'h2);
        seq = 16'hFFFE;
        aud(16'h1, 32'h30, 2'h2, 4'h0);
        aud(16'h1, 32'h30, 2'h2, 4'h0);
        rchk("seq wrap clean", A_ERR, 32'h0);
        aud(16'h2, 32'h30, 2'h2, 4'h0);
        rchk("sequence gap", A_ERR, 32'h2);
        chk("err_any set", 32'h1, {31'h0, err_any});
        apb(1'b1, A_CTRL, 32'h2);
        rchk("session clear", A_ERR, 32'h0);
        chk("err_any clear", 32'h0, {31'h0, err_any});
        aud(16'h1, 32'h30, 2'h2, 4'h0);
        aud(16'h1, 32'h31, 2'h2, 4'h0);
        rchk("audio ts step", A_ERR, 32'h4);
        apb(1'b1, A_CTRL, 32'h2);
        aud(16'h1, 32'h30, 2'h1, 4'h0);
        rchk("rtp version", A_ERR, 32'h8);
        apb(1'b1, A_CTRL, 32'h2);
        aud(16'h1, 32'h30, 2'h2, 4'h1);
        rchk("csrc count", A_ERR, 32'h10);
        $display("test audio checks done");
        apb(1'b1, A_VSTEP, 32'h1194);
        rchk("vstep write", A_VSTEP, 32'h1194);
        apb(1'b1, A_CTRL, 32'h3);
        vpk(1'b1, 32'h1194, 8'h0);
        vpk(1'b1, 32'h1194, 8'hFF - u_snd.fc_r);
        vpk(1'b1, 32'h1194, 8'h0);
        rchk("frame wrap clean", A_ERR, 32'h0);
        vpk(1'b0, 32'h1194, 8'h1);
        rchk("frame skip", A_ERR, 32'h1);
        apb(1'b1, A_CTRL, 32'h3);
        vpk(1'b0, 32'h1194, 8'h0);
        vpk(1'b0, 32'h30, 8'h0);
        rchk("video ts step", A_ERR, 32'h4);
        $display("test video checks done");
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: media_sender.sv */
// sender model: emits rtp datagrams word by word on the receive stream
// assumes it shares pclk with the monitor; the bench calls send
`timescale 1ns/10ps
`default_nettype none
module media_sender (
    // clock
    input wire logic    pclk,
    // receive stream
    output logic        rx_valid,
    output logic        rx_sop,
    output logic        rx_eop,
    output logic [31:0] rx_data
);
    logic [7:0]  fc_r  = 8'h00;
    logic [31:0] vts_r = 32'h0000_0000;

    initial begin
        rx_valid = 1'b0;
        rx_sop = 1'b0;
        rx_eop = 1'b0;
        rx_data = 32'h0000_0000;
    end

    always @(posedge pclk) vts_r <= vts_r + 32'h1;

    task automatic send(input logic vid, input logic [31:0] w0, input logic [31:0] ts,
                        input logic [31:0] hdr, input logic [31:0] fmt, input logic [7:0] skip);
        logic [31:0] q[$];
        logic [7:0]  frc;
        // skip models frames lost upstream
        frc = fc_r + skip;
        q = {w0, ts, 32'h5A5A_0001};
        repeat (w0[27:24]) q.push_back(32'hC5C5_0000);
        if (vid) begin
            q.push_back({hdr[31:24], frc, hdr[15:5], 5'h00});
            q.push_back(fmt);
            if (hdr[8:5] != 4'h0) q.push_back(vts_r);
            repeat (hdr[31:28]) q.push_back(32'hE7E7_0000);
        end
        q.push_back(32'hA000_0000);
        q.push_back(32'hA000_0001);
        foreach (q[i]) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_sop <= (i == 0);
            rx_eop <= (i == q.size() - 1);
            rx_data <= q[i];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_sop <= 1'b0;
        rx_eop <= 1'b0;
        // released bus must not look like a stale word
        rx_data <= ~q[q.size() - 1];
        fc_r <= w0[23] ? frc + 8'h01 : frc;
    endtask
endmodule
`default_nettype wire

/* File: mhm_pkg.sv */
// constants, field layout and types shared by the media header monitor
// assumes 32-bit APB data and a word-wide receive datagram stream
package mhm_pkg;
    // register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_ASTEP = 8'h04;
    localparam logic [7:0] A_VSTEP = 8'h08;
    localparam logic [7:0] A_ERR   = 8'h0C;
    localparam logic [7:0] A_RTP   = 8'h10;
    localparam logic [7:0] A_HBR   = 8'h14;
    localparam logic [7:0] A_FMT   = 8'h18;
    localparam logic [7:0] A_VTS   = 8'h1C;
    localparam logic [7:0] A_DEC   = 8'h20;
    // control bits
    localparam int C_VIDEO = 0;
    localparam int C_CLR   = 1;
    // reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] ASTEP_RST = 32'h0000_0030;
    localparam logic [31:0] VSTEP_RST = 32'h0000_0000;
    // rtp word 0 fields
    localparam int RT_VER = 30;
    localparam int RT_CC  = 24;
    localparam int RT_M   = 23;
    localparam logic [1:0] RTP_VER = 2'h2;
    // payload header word fields
    localparam int HB_EXT  = 28;
    localparam int HB_F    = 27;
    localparam int HB_VSID = 24;
    localparam int HB_FRC  = 16;
    localparam int HB_REF  = 14;
    localparam int HB_SCR  = 12;
    localparam int HB_FEC  = 9;
    localparam int HB_CF   = 5;
    localparam int HB_RSV  = 0;
    // source format word fields
    localparam int FM_MAP  = 28;
    localparam int FM_FRM  = 20;
    localparam int FM_RATE = 12;
    localparam int FM_SMP  = 8;
    // sticky error bits
    localparam int E_FC   = 0;
    localparam int E_SEQ  = 1;
    localparam int E_TS   = 2;
    localparam int E_VER  = 3;
    localparam int E_CSRC = 4;
    localparam int ERR_W  = 5;
    typedef enum logic [3:0] {
        ST_IDLE, ST_TS, ST_SSRC, ST_CSRC, ST_HBR, ST_FMT, ST_VTS, ST_EXT, ST_PAY
    } prs_state_t;
endpackage
